// ### verilog/gauge_pkg.sv
// Purpose: Shared constants for the duty-cycle gauge stepper positioner
// Assumes: 200 MHz system clock
// Notes:   Timer and position widths, patterns and timing counts live here
package gauge_pkg;

  // ----------------------------------------------------------------------
  // Timer and arithmetic widths
  // ----------------------------------------------------------------------
  localparam int          TIMER_W       = 24;
  localparam int          POS_W         = 7;
  localparam logic [6:0]  POSITION_MAX  = 7'h64;
  localparam logic [6:0]  HOME_STEPS    = 7'h64;
  localparam logic [6:0]  START_POS     = 7'h00;
  localparam logic [6:0]  PERCENT_SCALE = 7'h64;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int          CLK_MHZ       = 200;
  localparam int          DWELL_US      = 2000;
  localparam int          DWELL_CYCLES  = DWELL_US * CLK_MHZ;

  // ----------------------------------------------------------------------
  // Coil patterns, bit 0 winding A pos .. bit 3 winding B neg
  // ----------------------------------------------------------------------
  localparam logic [3:0]  PAT_0         = 4'h0A;
  localparam logic [3:0]  PAT_1         = 4'h09;
  localparam logic [3:0]  PAT_2         = 4'h05;
  localparam logic [3:0]  PAT_3         = 4'h06;
  localparam logic [3:0]  PAT_OFF       = 4'h0;

  // Capture sequencer states
  typedef enum logic [1:0] {CAP_WAIT_FIRST, CAP_WAIT_SECOND, CAP_WAIT_FALL,
                            CAP_DIVIDE} capture_state_type;

  // Motion states
  typedef enum logic [1:0] {MOT_HOMING, MOT_IDLE, MOT_STEP} motion_state_type;

endpackage

// ### verilog/duty_divider.sv
// Purpose: Sequential restoring divider for high_time*100/period
// Assumes: Operands stay stable only as long as start is pulsed once
// Notes:   One quotient bit per clock, result held until the next division completes
`timescale 1ns/1ps
module duty_divider (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          nrst,
  // Request
  input  wire logic                          start,
  input  wire logic [gauge_pkg::TIMER_W+6:0] dividend,
  input  wire logic [gauge_pkg::TIMER_W-1:0] divisor,
  // Answer
  output logic                               done,
  output logic      [gauge_pkg::TIMER_W+6:0] quotient
);

  localparam int N = gauge_pkg::TIMER_W + 7;

  logic [N-1:0]                    rem_q;
  logic [N-1:0]                    num;
  logic [gauge_pkg::TIMER_W-1:0]   den;
  logic [5:0]                      count;
  logic                            busy;
  logic [N:0]                      trial;
  logic                            fits;

  // Shift next dividend bit into remainder and test subtraction
  assign trial = {rem_q, num[N-1]};
  assign fits  = trial >= {{(N+1-gauge_pkg::TIMER_W){1'b0}}, den};

  // One restoring step per cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rem_q    <= '0;
      num      <= '0;
      den      <= '0;
      count    <= '0;
      busy     <= 1'b0;
      done     <= 1'b0;
      quotient <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        rem_q <= '0;
        num   <= dividend;
        den   <= divisor;
        count <= 6'(N);
        busy  <= 1'b1;
      end else if (busy) begin
        rem_q <= fits ? N'(trial - {{(N+1-gauge_pkg::TIMER_W){1'b0}}, den}) : trial[N-1:0];
        num   <= {num[N-2:0], fits};
        count <= count - 6'h01;
        if (count == 6'h01) begin
          busy     <= 1'b0;
          done     <= 1'b1;
          quotient <= {num[N-2:0], fits};
        end
      end
    end
  end

endmodule

// ### verilog/gauge_positioner.sv
// Purpose: Measure PWM duty cycle and drive a bipolar stepper gauge to it
// Assumes: Motor wired straight to COIL outputs, PWM on an async pin
// Notes:   One position per percent, 100 positions, homing after reset
`timescale 1ns/1ps
module gauge_positioner #(
  parameter int DWELL = gauge_pkg::DWELL_CYCLES
) (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       NRST,
  // PWM source
  input  wire logic       PWM_INPUT_PIN,
  // Stepper coils
  output logic      [3:0] OUTPUT_PORT_LINES,
  // Status
  output logic      [6:0] PRESENT_POSITION,
  output logic      [6:0] TARGET_POSITION,
  output logic            HOMING_BUSY
);

  localparam int TW = gauge_pkg::TIMER_W;

  // ----------------------------------------------------------------------
  // Input synchroniser and edge detection
  // ----------------------------------------------------------------------
  logic pwm_meta;
  logic pwm_sync;
  logic pwm_last;
  logic rise_edge;
  logic fall_edge;

  // Two stages before any logic looks at the pin
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pwm_meta <= 1'b0;
      pwm_sync <= 1'b0;
      pwm_last <= 1'b0;
    end else begin
      pwm_meta <= PWM_INPUT_PIN;
      pwm_sync <= pwm_meta;
      pwm_last <= pwm_sync;
    end
  end

  // Both transitions are detected, sequencer picks the armed one
  assign rise_edge = pwm_sync & ~pwm_last;
  assign fall_edge = ~pwm_sync & pwm_last;

  // ----------------------------------------------------------------------
  // Capture timer and sequencer
  // ----------------------------------------------------------------------
  gauge_pkg::capture_state_type cap_state;
  logic [TW-1:0]   timer;
  logic [TW-1:0]   period;
  logic [TW-1:0]   high_time;
  logic            div_start;
  logic            div_done;
  logic [TW+6:0]   quotient;
  logic [TW+6:0]   dividend;
  logic            timer_full;

  // Saturating timer avoids a wrapped period on a stalled input
  assign timer_full = &timer;
  // Multiply by 100 before dividing keeps the integer percentage exact
  assign dividend   = (TW+7)'(high_time) * (TW+7)'(gauge_pkg::PERCENT_SCALE);

  // Arm rising, rising, then falling; counter restarts at both armed rising edges
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cap_state <= gauge_pkg::CAP_WAIT_FIRST;
      timer     <= '0;
      period    <= '0;
      high_time <= '0;
      div_start <= 1'b0;
    end else begin
      div_start <= 1'b0;
      timer     <= timer_full ? timer : timer + TW'(1);
      case (cap_state)
        gauge_pkg::CAP_WAIT_FIRST: begin
          if (rise_edge) begin
            timer     <= '0;
            cap_state <= gauge_pkg::CAP_WAIT_SECOND;
          end
        end
        gauge_pkg::CAP_WAIT_SECOND: begin
          if (rise_edge) begin
            period    <= timer + TW'(1);
            timer     <= '0;
            cap_state <= gauge_pkg::CAP_WAIT_FALL;
          end
        end
        gauge_pkg::CAP_WAIT_FALL: begin
          if (fall_edge) begin
            high_time <= timer + TW'(1);
            if (period == '0) begin
              cap_state <= gauge_pkg::CAP_WAIT_FIRST;
            end else begin
              div_start <= 1'b1;
              cap_state <= gauge_pkg::CAP_DIVIDE;
            end
          end
        end
        gauge_pkg::CAP_DIVIDE: begin
          if (div_done) begin
            cap_state <= gauge_pkg::CAP_WAIT_FIRST;
          end
        end
        default: cap_state <= gauge_pkg::CAP_WAIT_FIRST;
      endcase
    end
  end

  // Sequential divider keeps the area small; a result takes about 31 cycles
  duty_divider u_div (
    .clk      (CLK),
    .nrst     (NRST),
    .start    (div_start),
    .dividend (dividend),
    .divisor  (period),
    .done     (div_done),
    .quotient (quotient)
  );

  // ----------------------------------------------------------------------
  // Target position
  // ----------------------------------------------------------------------
  logic       over_range;
  logic [6:0] clamped;

  // Ratio above the top position clamps to the last valid one
  assign over_range = quotient >= (TW+7)'(gauge_pkg::POSITION_MAX);
  assign clamped    = over_range ? gauge_pkg::POSITION_MAX - 7'h01 : quotient[6:0];

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      TARGET_POSITION <= gauge_pkg::START_POS;
    end else if (div_done) begin
      TARGET_POSITION <= clamped;
    end
  end

  // ----------------------------------------------------------------------
  // Motion sequencer
  // ----------------------------------------------------------------------
  gauge_pkg::motion_state_type mot_state;
  logic [31:0] dwell_cnt;
  logic        dwell_done;
  logic [1:0]  phase;
  logic [6:0]  home_left;
  logic        want_fwd;
  logic        want_back;
  logic [1:0]  next_phase;
  logic [3:0]  next_pattern;

  // Coil pattern for a phase index, used for forward and backward walks
  function automatic logic [3:0] phase_pattern(input logic [1:0] p);
    case (p)
      2'h0:    phase_pattern = gauge_pkg::PAT_0;
      2'h1:    phase_pattern = gauge_pkg::PAT_1;
      2'h2:    phase_pattern = gauge_pkg::PAT_2;
      default: phase_pattern = gauge_pkg::PAT_3;
    endcase
  endfunction

  assign dwell_done   = dwell_cnt == 32'(DWELL - 1);
  assign want_fwd     = TARGET_POSITION > PRESENT_POSITION;
  assign want_back    = TARGET_POSITION < PRESENT_POSITION;
  // Each step alternates which winding changes polarity
  assign next_phase   = (want_fwd && mot_state != gauge_pkg::MOT_HOMING)
                        ? phase + 2'h1 : phase - 2'h1;
  assign next_pattern = phase_pattern(next_phase);

  // A step is taken only after the present pattern has dwelt its full time
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mot_state         <= gauge_pkg::MOT_HOMING;
      dwell_cnt         <= '0;
      phase             <= 2'h0;
      home_left         <= gauge_pkg::HOME_STEPS;
      PRESENT_POSITION  <= gauge_pkg::START_POS;
      OUTPUT_PORT_LINES <= gauge_pkg::PAT_0;
      HOMING_BUSY       <= 1'b1;
    end else begin
      dwell_cnt <= dwell_done ? 32'h0000_0000 : dwell_cnt + 32'h0000_0001;
      case (mot_state)
        gauge_pkg::MOT_HOMING: begin
          if (dwell_done) begin
            if (home_left == 7'h00) begin
              PRESENT_POSITION <= gauge_pkg::START_POS;
              HOMING_BUSY      <= 1'b0;
              mot_state        <= gauge_pkg::MOT_IDLE;
            end else begin
              phase             <= next_phase;
              OUTPUT_PORT_LINES <= next_pattern;
              home_left         <= home_left - 7'h01;
            end
          end
        end
        gauge_pkg::MOT_IDLE: begin
          if (dwell_done && (want_fwd || want_back)) begin
            mot_state <= gauge_pkg::MOT_STEP;
          end
        end
        gauge_pkg::MOT_STEP: begin
          if (dwell_done) begin
            if (want_fwd || want_back) begin
              phase             <= next_phase;
              OUTPUT_PORT_LINES <= next_pattern;
              PRESENT_POSITION  <= want_fwd ? PRESENT_POSITION + 7'h01
                                            : PRESENT_POSITION - 7'h01;
            end else begin
              mot_state <= gauge_pkg::MOT_IDLE;
            end
          end
        end
        default: mot_state <= gauge_pkg::MOT_IDLE;
      endcase
    end
  end

endmodule

// ### test/gauge_positioner_properties.sv
// Purpose: Port-level assertions for the gauge positioner
// Assumes: Bound to every gauge_positioner instance
// Notes:   Dwell and homing counts come from small helper counters
`timescale 1ns/1ps
module gauge_positioner_properties #(
  parameter int DWELL = gauge_pkg::DWELL_CYCLES
) (
  // Watched ports
  input wire logic       CLK,
  input wire logic       NRST,
  input wire logic       PWM_INPUT_PIN,
  input wire logic [3:0] OUTPUT_PORT_LINES,
  input wire logic [6:0] PRESENT_POSITION,
  input wire logic [6:0] TARGET_POSITION,
  input wire logic       HOMING_BUSY
);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic [3:0] prev_lines;
  int         hold_len;
  int         home_steps;
  wire        moved = OUTPUT_PORT_LINES != prev_lines;

  // Reset pattern counts as settled, the dwell clock may start anywhere
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      prev_lines <= 4'hA;
      hold_len   <= DWELL;
      home_steps <= 0;
    end else begin
      prev_lines <= OUTPUT_PORT_LINES;
      hold_len   <= moved ? 1 : ((hold_len < DWELL) ? hold_len + 1 : hold_len);
      home_steps <= (moved && HOMING_BUSY) ? home_steps + 1 : home_steps;
    end
  end

  // Forward and backward successor of a coil pattern
  function automatic logic [3:0] fwd(input logic [3:0] p);
    fwd = (p == 4'hA) ? 4'h9 : (p == 4'h9) ? 4'h5 : (p == 4'h5) ? 4'h6 : 4'hA;
  endfunction
  function automatic logic [3:0] back(input logic [3:0] p);
    back = (p == 4'hA) ? 4'h6 : (p == 4'h6) ? 4'h5 : (p == 4'h5) ? 4'h9 : 4'hA;
  endfunction

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence s_step;
    $changed(OUTPUT_PORT_LINES);
  endsequence
  sequence s_fwd;
    s_step ##0 OUTPUT_PORT_LINES == fwd($past(OUTPUT_PORT_LINES));
  endsequence
  sequence s_back;
    s_step ##0 OUTPUT_PORT_LINES == back($past(OUTPUT_PORT_LINES));
  endsequence

  property p_legal;
    OUTPUT_PORT_LINES inside {4'hA, 4'h9, 4'h5, 4'h6};
  endproperty
  property p_fwd;
    PRESENT_POSITION == $past(PRESENT_POSITION) + 7'h1 |-> s_fwd;
  endproperty
  property p_back;
    PRESENT_POSITION == $past(PRESENT_POSITION) - 7'h1 |-> s_back;
  endproperty
  property p_home_dir;
    HOMING_BUSY && $changed(OUTPUT_PORT_LINES) |-> s_back;
  endproperty
  property p_pair;
    $changed(PRESENT_POSITION) |-> s_step;
  endproperty
  property p_range;
    PRESENT_POSITION <= 7'h63 && TARGET_POSITION <= 7'h63;
  endproperty
  property p_dwell;
    moved |-> hold_len >= DWELL;
  endproperty
  property p_home_len;
    $fell(HOMING_BUSY) |-> home_steps == 100 && PRESENT_POSITION == 7'h00;
  endproperty
  property p_toward;
    $changed(PRESENT_POSITION) && !HOMING_BUSY |->
      (PRESENT_POSITION > $past(PRESENT_POSITION)) ==
      ($past(TARGET_POSITION) > $past(PRESENT_POSITION));
  endproperty

  a_legal: assert property (p_legal) else $error("illegal coil pattern");
  a_fwd: assert property (p_fwd) else $error("bad forward pattern");
  a_back: assert property (p_back) else $error("bad backward pattern");
  a_home_dir: assert property (p_home_dir) else $error("homing not backward");
  a_pair: assert property (p_pair) else $error("position moved without step");
  a_range: assert property (p_range) else $error("position out of range");
  a_dwell: assert property (p_dwell) else $error("pattern held too briefly");
  a_home_len: assert property (p_home_len) else $error("homing count wrong");
  a_toward: assert property (p_toward) else $error("step away from target");
endmodule

bind gauge_positioner gauge_positioner_properties #(.DWELL(DWELL)) u_props (
  .CLK(CLK), .NRST(NRST), .PWM_INPUT_PIN(PWM_INPUT_PIN),
  .OUTPUT_PORT_LINES(OUTPUT_PORT_LINES), .PRESENT_POSITION(PRESENT_POSITION),
  .TARGET_POSITION(TARGET_POSITION), .HOMING_BUSY(HOMING_BUSY));

// ### test/pwm_source.sv
// Purpose: Free-running PWM source standing in for the sensor
// Assumes: Period and high time in clock cycles, high below period
// Notes:   Settings may change mid-period, counter wraps early if the new period is shorter
`timescale 1ns/1ps
module pwm_source (
  // Clock
  input wire logic        clk,
  // Settings
  input wire logic [15:0] period,
  input wire logic [15:0] high,
  // Output
  output logic            pin
);
  logic [15:0] cnt = 16'h0000;

  // Count just after the edge like any other bench driver
  always @(posedge clk) begin
    #1;
    cnt <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
  end
  assign pin = cnt < high;
endmodule

// ### test/gauge_positioner_tb_top.sv
// Purpose: Self-checking bench for the gauge positioner
// Assumes: Short dwell of 4 cycles keeps the run brief
// Notes:   Each setting waits for target, then for the motor to settle
`timescale 1ns/1ps
module gauge_positioner_tb_top;
  logic        clk;
  logic        nrst;
  wire         pwm_pin;
  logic [3:0]  lines;
  logic [6:0]  present;
  logic [6:0]  target;
  logic        busy;
  logic [15:0] period;
  logic [15:0] high;
  logic [15:0] lfsr;
  int          mismatches;
  int          checked;
  int          n;
  int          cp [4] = '{100, 250, 7, 100};
  int          ch [4] = '{99, 2, 3, 5};

  pwm_source src (.clk(clk), .period(period), .high(high), .pin(pwm_pin));
  gauge_positioner #(.DWELL(4)) DUT (
    .CLK(clk), .NRST(nrst), .PWM_INPUT_PIN(pwm_pin), .OUTPUT_PORT_LINES(lines),
    .PRESENT_POSITION(present), .TARGET_POSITION(target), .HOMING_BUSY(busy));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Floor of high*100/period, top position is 99
  function automatic logic [6:0] duty(input logic [15:0] p, input logic [15:0] h);
    int d;
    d = (h * 100) / p;
    return (d > 99) ? 7'h63 : 7'(d);
  endfunction
  // Homing leaves 0xA at position 0, forward steps walk the cycle
  function automatic logic [6:0] pat(input logic [6:0] p);
    logic [3:0] t [4] = '{4'hA, 4'h9, 4'h5, 4'h6};
    return {3'h0, t[p[1:0]]};
  endfunction

  task check(input logic [6:0] seen, input logic [6:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bounded wait on target, then on position; a timeout ends the run
  task settle(input logic [6:0] want);
    n = 0;
    while (target !== want && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(target, want);
    if (target !== want) summarize();
    n = 0;
    while (present !== want && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(present, want);
    check({3'h0, lines}, pat(want));
    if (present !== want) summarize();
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    period = 16'h0064;
    high = 16'h0025;
    lfsr = 16'hD45D;
    mismatches = 0;
    checked = 0;
    repeat (8) @(posedge clk);
    #1;
    check({3'h0, lines}, 7'h0A);
    check({6'h00, busy}, 7'h01);
    nrst = 1'b1;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({6'h00, busy}, 7'h00);
    check(present, 7'h00);
    if (busy !== 1'b0) summarize();
    settle(duty(period, high));
    for (int i = 0; i < 4; i++) begin
      period = 16'(cp[i]);
      high = 16'(ch[i]);
      settle(duty(period, high));
    end
    repeat (4) begin
      lfsr = lfsr_next(lfsr);
      period = 16'h0014 + lfsr % 16'h00C8;
      lfsr = lfsr_next(lfsr);
      high = 16'h0001 + lfsr % (period - 16'h0001);
      settle(duty(period, high));
    end
    summarize();
  end
endmodule
